// file: common/mrp_pkg.sv
// shared constants for the monitor result and pwm register bank
package mrp_pkg;
	// ==========================================================
	// register addresses (address bits 7 to 5 are ignored)
	localparam int ADDR_W = 5;
	localparam logic [ADDR_W-1:0] ADDR_CTL = 5'h08;
	localparam logic [ADDR_W-1:0] ADDR_THR = 5'h09;
	localparam logic [ADDR_W-1:0] ADDR_VI_HI = 5'h0A;
	localparam logic [ADDR_W-1:0] ADDR_VI_LO = 5'h0B;
	localparam logic [ADDR_W-1:0] ADDR_DI_HI = 5'h0C;
	localparam logic [ADDR_W-1:0] ADDR_DI_LO = 5'h0D;
	localparam logic [ADDR_W-1:0] ADDR_T_HI = 5'h1A;
	localparam logic [ADDR_W-1:0] ADDR_T_LO = 5'h1B;
	// ==========================================================
	// control register fields
	localparam int CTL_THR_LSB = 7;
	localparam int CTL_PWM_INV = 6;
	localparam int CTL_PWM_EN = 5;
	localparam int CTL_REPEAT = 4;
	localparam int CTL_FILT = 3;
	localparam int CTL_KELVIN = 2;
	localparam logic [7:0] CTL_WR_MASK = 8'hFC;
	// ==========================================================
	// result high byte fields
	localparam int HI_FRESH = 7;
	localparam int HI_SIGN = 6;
	// ==========================================================
	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [8:0] RST_THR9 = 9'h000;
	// ==========================================================
	// result formats and scaling
	localparam int VI_W = 14;
	localparam int T_W = 13;
	localparam int PWM_W = 9;
	localparam int T_FRAC_BITS = 4;
	localparam logic [T_W-1:0] KELVIN_OFFSET = 13'h1112;
	localparam int FILT_SHIFT = 2;
	localparam real SE_LSB_UV = 305.18;
	localparam real DIFF_LSB_UV = 19.075;
	localparam real SUPPLY_OFFSET_V = 2.5;
	localparam real TEMP_LSB_DEG = 0.0625;
endpackage

// file: src/mrp_pwm_gen.sv
// pulse-width generator driving the temperature output pin
`timescale 1ns/1ps
`default_nettype none
module mrp_pwm_gen #(
	parameter int W = 9
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic srst_i,
	// control
	input wire logic enable_i,
	input wire logic invert_i,
	input wire logic [W-1:0] duty_i,
	// pin
	output logic pwm_o
);
	// ==========================================================
	// period counter
	logic [W-1:0] cnt;
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			cnt <= '0;
		end else begin
			cnt <= cnt + 1'b1;
		end
	end
	// ==========================================================
	// output, idle level follows polarity
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			pwm_o <= 1'b0;
		end else if (enable_i) begin
			pwm_o <= (cnt < duty_i) ^ invert_i;
		end else begin
			pwm_o <= invert_i;
		end
	end
endmodule // mrp_pwm_gen
`default_nettype wire

// file: src/mrp_regs.sv
// result registers, control register and pwm output of the monitor
//
// Functional notes
// - Control bit 5 enables the pwm output; clear by default.
// - Control bit 6 inverts pwm polarity; clear means not inverted.
// - Disabled pwm pin sits at 0, or at 1 when inverted.
// - Non-inverted duty cycle rises as measured temperature rises.
// - Control bit 4 selects repeated acquisition, else single shot.
// - Control bit 3 filters the internal die temperature result.
// - Control bit 2 reports die temperature in Kelvin, else Celsius.
// - Nine-bit threshold: bits 8..1 from threshold register, bit 0 control bit 7.
// - Fresh flag in high byte bit 7 sets on new result, clears on read.
// - Voltage/current high byte: sign bit 6, result bits 13..8 below.
// - Temperature high byte: bits 6,5 unused, result bits 12..8 below.
// - Diode high byte: fresh bit 7, bits 6,5 unused, bits 12..8 below.
// - Single-ended voltage scale is 305.18 microvolts per step.
// - Differential voltage scale is 19.075 microvolts per step.
// - Supply reading is result plus 2.5 volts, single-ended scale.
// - Control register resets to 00h: pwm off, single shot, Celsius.
// - Reset clears every register to 00h.
// - Temperature scale is 0.0625 degrees per step.
`timescale 1ns/1ps
`default_nettype none
module mrp_regs (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic srst_i,
	// register access port
	input wire logic [7:0] addr_i,
	input wire logic wr_i,
	input wire logic [7:0] wdata_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// voltage/current result from converter
	input wire logic vi_wr_i,
	input wire logic vi_sign_i,
	input wire logic [mrp_pkg::VI_W-1:0] vi_data_i,
	// die temperature result from converter, Celsius
	input wire logic temp_wr_i,
	input wire logic [mrp_pkg::T_W-1:0] temp_data_i,
	// diode voltage result from converter
	input wire logic diode_wr_i,
	input wire logic [mrp_pkg::T_W-1:0] diode_data_i,
	// acquisition and pwm
	output logic acq_repeat_o,
	output logic pwm_o
);
	import mrp_pkg::*;

	// ==========================================================
	// address decode shared by write and read paths
	function automatic logic hit(input logic [7:0] a, input logic [ADDR_W-1:0] reg_addr);
		hit = (a[ADDR_W-1:0] == reg_addr);
	endfunction

	logic [7:0] ctl_q;
	logic [7:0] thr_q;
	logic [7:0] vi_hi;
	logic [7:0] vi_lo;
	logic [7:0] t_hi;
	logic [7:0] t_lo;
	logic [7:0] di_hi;
	logic [7:0] di_lo;
	logic [T_W-1:0] filt_q;
	logic [T_W-1:0] next_temp;
	logic [T_W-1:0] temp_sel;
	logic [T_W-1:0] filt_step;
	logic [PWM_W-1:0] threshold;
	logic [PWM_W-1:0] temp_deg;
	logic [PWM_W-1:0] duty;
	logic rd_vi_hi;
	logic rd_t_hi;
	logic rd_di_hi;

	// ==========================================================
	// control and threshold registers
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			ctl_q <= RST_BYTE;
		end else if (wr_i && hit(addr_i, ADDR_CTL)) begin
			ctl_q <= wdata_i & CTL_WR_MASK;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			thr_q <= RST_BYTE;
		end else if (wr_i && hit(addr_i, ADDR_THR)) begin
			thr_q <= wdata_i;
		end
	end

	assign threshold = {thr_q, ctl_q[CTL_THR_LSB]};

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			acq_repeat_o <= 1'b0;
		end else begin
			acq_repeat_o <= ctl_q[CTL_REPEAT];
		end
	end

	// ==========================================================
	// die temperature conditioning
	// first-order filter; a shift keeps it multiplier free at the cost of a fixed corner
	assign temp_sel = ctl_q[CTL_KELVIN] ? T_W'(temp_data_i + KELVIN_OFFSET) : temp_data_i;
	assign filt_step = T_W'($signed(temp_sel - filt_q) >>> FILT_SHIFT);
	assign next_temp = ctl_q[CTL_FILT] ? T_W'(filt_q + filt_step) : temp_sel;

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			filt_q <= '0;
		end else if (temp_wr_i) begin
			filt_q <= next_temp;
		end
	end

	// ==========================================================
	// read strobes that clear the fresh flags
	assign rd_vi_hi = rd_i && hit(addr_i, ADDR_VI_HI);
	assign rd_t_hi = rd_i && hit(addr_i, ADDR_T_HI);
	assign rd_di_hi = rd_i && hit(addr_i, ADDR_DI_HI);

	// ==========================================================
	// voltage/current result; a new result beats a clearing read
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			vi_hi <= RST_BYTE;
			vi_lo <= RST_BYTE;
		end else if (vi_wr_i) begin
			vi_hi <= {1'b1, vi_sign_i, vi_data_i[13:8]};
			vi_lo <= vi_data_i[7:0];
		end else if (rd_vi_hi) begin
			vi_hi[HI_FRESH] <= 1'b0;
		end
	end

	// ==========================================================
	// temperature result
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			t_hi <= RST_BYTE;
			t_lo <= RST_BYTE;
		end else if (temp_wr_i) begin
			t_hi <= {1'b1, 2'b00, next_temp[12:8]};
			t_lo <= next_temp[7:0];
		end else if (rd_t_hi) begin
			t_hi[HI_FRESH] <= 1'b0;
		end
	end

	// ==========================================================
	// diode voltage result
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			di_hi <= RST_BYTE;
			di_lo <= RST_BYTE;
		end else if (diode_wr_i) begin
			di_hi <= {1'b1, 2'b00, diode_data_i[12:8]};
			di_lo <= diode_data_i[7:0];
		end else if (rd_di_hi) begin
			di_hi[HI_FRESH] <= 1'b0;
		end
	end

	// ==========================================================
	// read data, one cycle after the strobe; unmapped reads give 00h
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			rdata_o <= RST_BYTE;
		end else if (rd_i) begin
			case (addr_i[ADDR_W-1:0])
				ADDR_CTL: rdata_o <= ctl_q;
				ADDR_THR: rdata_o <= thr_q;
				ADDR_VI_HI: rdata_o <= vi_hi;
				ADDR_VI_LO: rdata_o <= vi_lo;
				ADDR_T_HI: rdata_o <= t_hi;
				ADDR_T_LO: rdata_o <= t_lo;
				ADDR_DI_HI: rdata_o <= di_hi;
				ADDR_DI_LO: rdata_o <= di_lo;
				default: rdata_o <= RST_BYTE;
			endcase
		end
	end

	// ==========================================================
	// duty from whole degrees above threshold
	// negative Celsius counts as zero duty, the pin never wraps to full on when cold
	assign temp_deg = (!ctl_q[CTL_KELVIN] && t_hi[4]) ? '0 : {t_hi[4:0], t_lo[7:4]};
	assign duty = (temp_deg > threshold) ? PWM_W'(temp_deg - threshold) : '0;

	mrp_pwm_gen #(
		.W(PWM_W)
	) u_pwm (
		.core_clk_i(core_clk_i),
		.srst_i(srst_i),
		.enable_i(ctl_q[CTL_PWM_EN]),
		.invert_i(ctl_q[CTL_PWM_INV]),
		.duty_i(duty),
		.pwm_o(pwm_o)
	);

	// ==========================================================
	// scaling of the codes is fixed by the analogue side:
	// single-ended SE_LSB_UV differential DIFF_LSB_UV
	// supply code plus SUPPLY_OFFSET_V temperature TEMP_LSB_DEG

	// ==========================================================
	// checks
	a_pwm_idle_level: assert property (@(posedge core_clk_i) disable iff (srst_i)
		!ctl_q[CTL_PWM_EN] |=> pwm_o == $past(ctl_q[CTL_PWM_INV]))
		else $error("pwm idle level wrong");

	a_pwm_zero_duty: assert property (@(posedge core_clk_i) disable iff (srst_i)
		(ctl_q[CTL_PWM_EN] && duty == '0) |=> pwm_o == $past(ctl_q[CTL_PWM_INV]))
		else $error("pwm polarity wrong at zero duty");

	a_fresh_set: assert property (@(posedge core_clk_i) disable iff (srst_i)
		(vi_wr_i || temp_wr_i) |=> (!$past(vi_wr_i) || vi_hi[HI_FRESH])
			&& (!$past(temp_wr_i) || t_hi[HI_FRESH]))
		else $error("fresh flag not set by new result");

	a_fresh_clear: assert property (@(posedge core_clk_i) disable iff (srst_i)
		(rd_di_hi && !diode_wr_i) |=> !di_hi[HI_FRESH])
		else $error("fresh flag not cleared by read");

	a_vi_layout: assert property (@(posedge core_clk_i) disable iff (srst_i)
		vi_wr_i |=> vi_hi[6:0] == {$past(vi_sign_i), $past(vi_data_i[13:8])}
			&& vi_lo == $past(vi_data_i[7:0]))
		else $error("voltage result layout wrong");

	a_reserved_zero: assert property (@(posedge core_clk_i) disable iff (srst_i)
		ctl_q[1:0] == 2'b00 && t_hi[6:5] == 2'b00 && di_hi[6:5] == 2'b00)
		else $error("reserved bits not zero");

	a_thr_write: assert property (@(posedge core_clk_i) disable iff (srst_i)
		(wr_i && hit(addr_i, ADDR_THR)) |=> threshold[8:1] == $past(wdata_i))
		else $error("threshold write lost");

	a_repeat_follow: assert property (@(posedge core_clk_i) disable iff (srst_i)
		(wr_i && hit(addr_i, ADDR_CTL)) |=> ##1 acq_repeat_o == $past(wdata_i[CTL_REPEAT], 2))
		else $error("repeat mode output wrong");

	a_kelvin_shift: assert property (@(posedge core_clk_i) disable iff (srst_i)
		(temp_wr_i && ctl_q[CTL_KELVIN] && !ctl_q[CTL_FILT])
			|=> {t_hi[4:0], t_lo} == T_W'($past(temp_data_i) + KELVIN_OFFSET))
		else $error("Kelvin offset wrong");

	a_reset_clear: assert property (@(posedge core_clk_i) disable iff (srst_i)
		$fell(srst_i) |-> ctl_q == RST_BYTE && thr_q == RST_BYTE && vi_hi == RST_BYTE
			&& rdata_o == RST_BYTE)
		else $error("registers not cleared by reset");
endmodule // mrp_regs
`default_nettype wire

// file: tb/mrp_host_model.sv
// parallel register port master model issuing register writes and reads
`timescale 1ns/1ps
`default_nettype none
module mrp_host_model (
	// clock
	input wire logic core_clk_i,
	// register port
	output logic [7:0] addr_o,
	output logic wr_o,
	output logic [7:0] wdata_o,
	output logic rd_o,
	input wire logic [7:0] rdata_i
);
	initial begin
		addr_o = 8'h00;
		wdata_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	// released data is inverted so stale values never look valid
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk_i);
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(negedge core_clk_i);
		wr_o = 1'b0;
		wdata_o = ~d;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(negedge core_clk_i);
		addr_o = a;
		rd_o = 1'b1;
		@(negedge core_clk_i);
		rd_o = 1'b0;
		d = rdata_i;
	endtask
endmodule // mrp_host_model
`default_nettype wire

// file: tb/mrp_regs_tb.sv
// self-checking bench for the monitor result and pwm register bank
`timescale 1ns/1ps
`default_nettype none
module mrp_regs_tb;
	import mrp_pkg::*;
	logic core_clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic [7:0] addr, wdata, rdata, rb;
	logic wr, rd, vi_wr, vi_sign, temp_wr, diode_wr, acq_repeat, pwm;
	logic [VI_W-1:0] vi_data;
	logic [T_W-1:0] temp_data, diode_data;
	logic [4:0] adr [8] = '{ADDR_CTL, ADDR_THR, ADDR_VI_HI, ADDR_VI_LO,
		ADDR_DI_HI, ADDR_DI_LO, ADDR_T_HI, ADDR_T_LO};
	int mismatches = 0;
	int total_checks = 0;
	int cycles = 0;
	initial forever #20 core_clk_i = ~core_clk_i;
	// ==========================================================
	// design and bus master
	mrp_regs i_mrp_regs (.core_clk_i(core_clk_i), .srst_i(srst_i), .addr_i(addr),
		.wr_i(wr), .wdata_i(wdata), .rd_i(rd), .rdata_o(rdata), .vi_wr_i(vi_wr),
		.vi_sign_i(vi_sign), .vi_data_i(vi_data), .temp_wr_i(temp_wr),
		.temp_data_i(temp_data), .diode_wr_i(diode_wr), .diode_data_i(diode_data),
		.acq_repeat_o(acq_repeat), .pwm_o(pwm));
	mrp_host_model i_mrp_host_model (.core_clk_i(core_clk_i), .addr_o(addr), .wr_o(wr),
		.wdata_o(wdata), .rd_o(rd), .rdata_i(rdata));
	// ==========================================================
	// helpers
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// whole run needs about 3200 cycles
	always @(posedge core_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			results();
		end
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		i_mrp_host_model.wr_reg(a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		i_mrp_host_model.rd_reg(a, rb);
		chk({8'h00, rb}, {8'h00, exp});
	endtask
	task automatic res(input int k, input logic [15:0] v, input logic s);
		@(negedge core_clk_i);
		vi_sign = s;
		vi_data = v[13:0];
		temp_data = v[12:0];
		diode_data = v[12:0];
		vi_wr = (k == 0);
		temp_wr = (k == 1);
		diode_wr = (k == 2);
		@(negedge core_clk_i);
		{vi_wr, temp_wr, diode_wr} = 3'b000;
	endtask
	// counts high samples over one full 512-cycle pwm period
	task automatic pwm_hi(input logic [7:0] ctl, input logic [15:0] exp);
		logic [15:0] n;
		n = 16'h0000;
		wr_reg({3'b000, ADDR_CTL}, ctl);
		@(negedge core_clk_i);
		repeat (512) begin
			@(negedge core_clk_i);
			n = n + {15'h0000, pwm};
		end
		chk(n, exp);
	endtask
	// ==========================================================
	// scenarios
	task automatic t_reset();
		foreach (adr[i]) rdc({3'b000, adr[i]}, 8'h00);
		chk({15'h0, acq_repeat}, 16'h0000);
		chk({15'h0, pwm}, 16'h0000);
	endtask
	task automatic t_ctl();
		wr_reg(8'hE8, 8'hFF);
		rdc({3'b000, ADDR_CTL}, 8'hFC);
		chk({15'h0, acq_repeat}, 16'h0001);
		wr_reg({3'b000, ADDR_VI_LO}, 8'h55);
		rdc({3'b000, ADDR_VI_LO}, 8'h00);
		wr_reg({3'b000, ADDR_CTL}, 8'h00);
		rdc(8'h00, 8'h00);
		chk({15'h0, acq_repeat}, 16'h0000);
	endtask
	task automatic t_results();
		logic [12:0] kv;
		res(0, 16'h2ABC, 1'b1);
		rdc({3'b000, ADDR_VI_HI}, 8'hEA);
		rdc({3'b000, ADDR_VI_HI}, 8'h6A);
		rdc({3'b000, ADDR_VI_LO}, 8'hBC);
		res(2, 16'h1234, 1'b1);
		rdc({3'b000, ADDR_DI_HI}, 8'h92);
		rdc({3'b000, ADDR_DI_LO}, 8'h34);
		res(1, 16'h1F90, 1'b1);
		rdc({3'b000, ADDR_T_HI}, 8'h9F);
		rdc({3'b000, ADDR_T_LO}, 8'h90);
		// filter state follows every temperature result, so it starts from 0x1F90: a quarter of 0x0200 on top
		wr_reg({3'b000, ADDR_CTL}, 8'h08);
		res(1, 16'h0190, 1'b0);
		rdc({3'b000, ADDR_T_HI}, 8'h80);
		rdc({3'b000, ADDR_T_LO}, 8'h10);
		wr_reg({3'b000, ADDR_CTL}, 8'h04);
		res(1, 16'h0190, 1'b0);
		kv = 13'h0190 + KELVIN_OFFSET;
		rdc({3'b000, ADDR_T_HI}, {3'b100, kv[12:8]});
		rdc({3'b000, ADDR_T_LO}, kv[7:0]);
		// new result and clearing read in one cycle: the read sees old data, the new result sets the flag
		fork
			res(1, 16'h0190, 1'b0);
			i_mrp_host_model.rd_reg({3'b000, ADDR_T_HI}, rb);
		join
		chk({8'h00, rb}, {11'h000, kv[12:8]});
		rdc({3'b000, ADDR_T_HI}, {3'b100, kv[12:8]});
	endtask
	task automatic t_pwm();
		wr_reg({3'b000, ADDR_CTL}, 8'h00);
		res(1, 16'h0190, 1'b0);
		pwm_hi(8'h00, 16'd0);
		pwm_hi(8'h40, 16'd512);
		pwm_hi(8'h20, 16'd25);
		wr_reg({3'b000, ADDR_THR}, 8'h05);
		pwm_hi(8'hA0, 16'd14);
		pwm_hi(8'hE0, 16'd498);
		res(1, 16'h0320, 1'b0);
		pwm_hi(8'hA0, 16'd39);
	endtask
	initial begin
		{vi_wr, vi_sign, temp_wr, diode_wr} = 4'h0;
		vi_data = '0;
		temp_data = '0;
		diode_data = '0;
		repeat (16) @(negedge core_clk_i);
		srst_i = 1'b0;
		t_reset();
		t_ctl();
		t_results();
		t_pwm();
		results();
	end
endmodule // mrp_regs_tb
`default_nettype wire
